// file: hw/ptmr_pkg.sv
package ptmr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIPHERAL_ENABLES_ONE = 8'h04;
  localparam logic [7:0] OFS_PERIPHERAL_FLAGS_ONE = 8'h08;
  localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_COUNT_VALUE = 8'h10;
  localparam logic [7:0] OFS_TIMER_TWO_CONTROL = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POSTSCALE_LSB = 3;
  localparam int RUN_BIT = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int MATCH_FLAG_BIT = 1;
  localparam int MATCH_IE_BIT = 1;
  localparam int GLOBAL_IE_BIT = 7;
  localparam int PERIPH_IE_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_COUNT_VALUE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;

  // Implemented-bit masks
  localparam logic [7:0] MASK_CONTROL = 8'h7F;
  localparam logic [7:0] MASK_PIR_PIE = 8'h7F;

  // Prescale division counts minus one
  localparam logic [3:0] PRE_DIV1_LAST = 4'h0;
  localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hF;

  // Bus state
  typedef enum logic [0:0] {APB_IDLE, APB_DONE} ptmr_apb_e;

endpackage : ptmr_pkg

// file: hw/ptmr_top.sv
// Function
// - Control: postscale bits 6:3, run bit 2, prescale bits 1:0, bit 7 zero.
// - Postscaler gives one flag per (postscale value plus one) period matches.
// - Prescale 00 divides by 1, 01 by 4, 1x by 16.
// - Period limit resets to all ones.
// - Count value resets to zero.
// - Reset clears implemented control bits: stopped, prescale 1, postscale 1:1.
// - Match flag is bit 1 of flag register; bit 7 reads zero; resets clear.
// - Match enable is bit 1 of enable register; all enables reset to zero.
// - Global enable bit 7, peripheral enable bit 6, cleared on reset.
`timescale 1ns/10ps
module ptmr_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupts
  output logic core_irq,
  output logic event_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] limit_r, limit_nxt;
  logic [7:0] count_r, count_nxt;
  logic [7:0] pie_r, pie_nxt;
  logic [7:0] pir_r, pir_nxt;
  logic [1:0] interrupt_control_r, interrupt_control_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [3:0] post_r, post_nxt;
  logic [1:0] sts_r, sts_nxt;
  logic [1:0] ien_r, ien_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic core_irq_r, core_irq_nxt;
  logic event_irq_r, event_irq_nxt;
  ptmr_pkg::ptmr_apb_e apb_r, apb_nxt;

  logic wr_en, rd_en, hit, tick, wrap, match_evt;
  logic [3:0] pre_last;

  // Address decode shared by reads and writes
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      ptmr_pkg::OFS_INTERRUPT_CONTROL, ptmr_pkg::OFS_PERIPHERAL_ENABLES_ONE,
      ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE, ptmr_pkg::OFS_PERIOD_LIMIT,
      ptmr_pkg::OFS_COUNT_VALUE, ptmr_pkg::OFS_TIMER_TWO_CONTROL,
      ptmr_pkg::OFS_IRQ_STATUS, ptmr_pkg::OFS_IRQ_ENABLE,
      ptmr_pkg::OFS_IRQ_CLEAR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // ----------------------------------------------------------------
  // Bus handshake: one wait state, access completes on the second edge
  // ----------------------------------------------------------------
  assign hit = psel && penable && (apb_r == ptmr_pkg::APB_IDLE);
  assign wr_en = hit && pwrite && mapped(paddr);
  assign rd_en = hit && !pwrite;

  // Prescaler terminal count per select code
  always_comb begin
    case (ctrl_r[ptmr_pkg::PRESCALE_LSB +: 2])
      2'b00: pre_last = ptmr_pkg::PRE_DIV1_LAST;
      2'b01: pre_last = ptmr_pkg::PRE_DIV4_LAST;
      default: pre_last = ptmr_pkg::PRE_DIV16_LAST;
    endcase
  end

  // Tick only while running; a count write overrides the tick's count and scaler steps, but a wrap still sets its flags
  assign tick = ctrl_r[ptmr_pkg::RUN_BIT] && (pre_r >= pre_last);
  assign wrap = tick && (count_r == limit_r);
  assign match_evt = wrap && (post_r == ctrl_r[ptmr_pkg::POSTSCALE_LSB +: 4]);

  // Next-state logic for timer and registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    limit_nxt = limit_r;
    count_nxt = count_r;
    pie_nxt = pie_r;
    pir_nxt = pir_r;
    interrupt_control_nxt = interrupt_control_r;
    pre_nxt = pre_r;
    post_nxt = post_r;
    sts_nxt = sts_r;
    ien_nxt = ien_r;
    apb_nxt = hit ? ptmr_pkg::APB_DONE : ptmr_pkg::APB_IDLE;
    // Prescaler advances only while running; stopping freezes it
    if (ctrl_r[ptmr_pkg::RUN_BIT]) begin
      pre_nxt = tick ? 4'h0 : pre_r + 4'h1;
    end
    if (tick) begin
      count_nxt = wrap ? 8'h00 : count_r + 8'h01;
    end
    if (wrap) begin
      post_nxt = match_evt ? 4'h0 : post_r + 4'h1;
    end
    // Software writes
    if (wr_en) begin
      case (paddr)
        ptmr_pkg::OFS_INTERRUPT_CONTROL: interrupt_control_nxt = pwdata[7:6];
        ptmr_pkg::OFS_PERIPHERAL_ENABLES_ONE: pie_nxt = pwdata[7:0] & ptmr_pkg::MASK_PIR_PIE;
        ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE: pir_nxt = pwdata[7:0] & ptmr_pkg::MASK_PIR_PIE;
        ptmr_pkg::OFS_PERIOD_LIMIT: limit_nxt = pwdata[7:0];
        ptmr_pkg::OFS_COUNT_VALUE: begin
          // Writing the count also clears both scalers
          count_nxt = pwdata[7:0];
          pre_nxt = 4'h0;
          post_nxt = 4'h0;
        end
        ptmr_pkg::OFS_TIMER_TWO_CONTROL: begin
          // Restart both scalers: a smaller postscale could otherwise be overrun
          ctrl_nxt = pwdata[7:0] & ptmr_pkg::MASK_CONTROL;
          pre_nxt = 4'h0;
          post_nxt = 4'h0;
        end
        ptmr_pkg::OFS_IRQ_ENABLE: ien_nxt = pwdata[1:0];
        ptmr_pkg::OFS_IRQ_CLEAR: sts_nxt = sts_r & ~pwdata[1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (match_evt) begin
      pir_nxt[ptmr_pkg::MATCH_FLAG_BIT] = 1'b1;
      sts_nxt[0] = 1'b1;
    end
    if (wrap) begin
      sts_nxt[1] = 1'b1;
    end
  end

  // Read mux and response
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = hit;
    pslverr_nxt = hit && !mapped(paddr);
    if (rd_en) begin
      case (paddr)
        ptmr_pkg::OFS_INTERRUPT_CONTROL: prdata_nxt = {24'h0, interrupt_control_r, 6'h00};
        ptmr_pkg::OFS_PERIPHERAL_ENABLES_ONE: prdata_nxt = {24'h0, pie_r};
        ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE: prdata_nxt = {24'h0, pir_r};
        ptmr_pkg::OFS_PERIOD_LIMIT: prdata_nxt = {24'h0, limit_r};
        ptmr_pkg::OFS_COUNT_VALUE: prdata_nxt = {24'h0, count_r};
        ptmr_pkg::OFS_TIMER_TWO_CONTROL: prdata_nxt = {24'h0, ctrl_r};
        ptmr_pkg::OFS_IRQ_STATUS: prdata_nxt = {30'h0, sts_r};
        ptmr_pkg::OFS_IRQ_ENABLE: prdata_nxt = {30'h0, ien_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Interrupt outputs: core path needs match enable, peripheral and global enables
  always_comb begin
    core_irq_nxt = pir_nxt[ptmr_pkg::MATCH_FLAG_BIT] && pie_nxt[ptmr_pkg::MATCH_IE_BIT]
                   && interrupt_control_nxt[1] && interrupt_control_nxt[0];
    event_irq_nxt = |(sts_nxt & ien_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ptmr_pkg::RST_CONTROL;
      limit_r <= ptmr_pkg::RST_PERIOD_LIMIT;
      count_r <= ptmr_pkg::RST_COUNT_VALUE;
      pie_r <= ptmr_pkg::RST_ENABLES;
      pir_r <= ptmr_pkg::RST_FLAGS;
      interrupt_control_r <= ptmr_pkg::RST_INTERRUPT_CONTROL[7:6];
      pre_r <= 4'h0;
      post_r <= 4'h0;
      sts_r <= 2'b00;
      ien_r <= 2'b00;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      core_irq_r <= 1'b0;
      event_irq_r <= 1'b0;
      apb_r <= ptmr_pkg::APB_IDLE;
    end else begin
      ctrl_r <= ctrl_nxt;
      limit_r <= limit_nxt;
      count_r <= count_nxt;
      pie_r <= pie_nxt;
      pir_r <= pir_nxt;
      interrupt_control_r <= interrupt_control_nxt;
      pre_r <= pre_nxt;
      post_r <= post_nxt;
      sts_r <= sts_nxt;
      ien_r <= ien_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      core_irq_r <= core_irq_nxt;
      event_irq_r <= event_irq_nxt;
      apb_r <= apb_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_irq = core_irq_r;
  assign event_irq = event_irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Wrap that software does not override in the same cycle
  sequence s_wrap;
    wrap && !wr_en;
  endsequence

  // Middle wraps of a flag period, where the postscaler only steps
  sequence s_mid_wrap;
    wrap && !match_evt && !wr_en;
  endsequence

  // Unimplemented control bit never stores a one
  a_ctrl_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[7] == 1'b0)
    else $error("control bit 7 set");

  // A stopped timer keeps its count until software writes
  a_stopped_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_r[ptmr_pkg::RUN_BIT] && !wr_en) |=> $stable(count_r))
    else $error("count moved while stopped");

  // Stopping freezes the prescaler too; the control write that restarts the timer clears it to zero
  a_stopped_prescale: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_r[ptmr_pkg::RUN_BIT] && !wr_en) |=> $stable(pre_r))
    else $error("prescaler moved while stopped");

  // Postscaler never passes the selected ratio; control writes restart it
  a_post_bound: assert property (@(posedge pclk) disable iff (!presetn)
    post_r <= ctrl_r[ptmr_pkg::POSTSCALE_LSB +: 4])
    else $error("postscaler beyond ratio");

  // A wrap short of the ratio advances the postscaler by one
  a_post_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_mid_wrap |=> post_r == $past(post_r) + 4'h1)
    else $error("postscaler did not step");

  // Ticks fall only on the last prescaler count
  a_pre_div: assert property (@(posedge pclk) disable iff (!presetn)
    tick |-> pre_r == pre_last)
    else $error("tick not at prescale count");

  // Ticks below the limit add exactly one to the count
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !wrap && !wr_en) |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step");

  // Reaching the limit restarts the count at zero
  a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap |=> count_r == 8'h00)
    else $error("count did not wrap");

  // The last match of a period raises the flag
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    match_evt |=> pir_r[ptmr_pkg::MATCH_FLAG_BIT])
    else $error("match flag not set");

  // The flag stays set until software rewrites the flag register
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (pir_r[ptmr_pkg::MATCH_FLAG_BIT]
      && !(wr_en && paddr == ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE))
      |=> pir_r[ptmr_pkg::MATCH_FLAG_BIT])
    else $error("match flag dropped");

  // Unimplemented flag and enable bits never store a one
  a_pir_bit7: assert property (@(posedge pclk) disable iff (!presetn)
    !pir_r[7] && !pie_r[7])
    else $error("flag or enable bit 7 set");

  // Core line only with flag, match enable and both upper enables
  a_core_gate: assert property (@(posedge pclk) disable iff (!presetn)
    core_irq |-> interrupt_control_r == 2'b11 && pie_r[1] && pir_r[1])
    else $error("core interrupt without enables");

  // All three enables and the flag together must raise the core line
  a_core_on: assert property (@(posedge pclk) disable iff (!presetn)
    (pir_r[1] && pie_r[1] && interrupt_control_r == 2'b11) |-> core_irq)
    else $error("core interrupt missing");

  // Event line follows the enabled status bits with no extra delay
  a_event_level: assert property (@(posedge pclk) disable iff (!presetn)
    event_irq == |(sts_r & ien_r))
    else $error("event interrupt level wrong");

  // Ready is a single-cycle pulse, so an access is never answered twice
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // Error response only travels with ready
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  // Timer registers at their reset values on the first edge after release
  a_reset_timer: assert property (@(posedge pclk)
    $rose(presetn) |-> (limit_r == ptmr_pkg::RST_PERIOD_LIMIT
      && count_r == ptmr_pkg::RST_COUNT_VALUE && ctrl_r == ptmr_pkg::RST_CONTROL))
    else $error("timer registers not at reset values");

  // Interrupt state cleared by reset, so no stale request survives it
  a_reset_irq: assert property (@(posedge pclk)
    $rose(presetn) |-> (pir_r == ptmr_pkg::RST_FLAGS && pie_r == ptmr_pkg::RST_ENABLES
      && interrupt_control_r == 2'b00 && !core_irq))
    else $error("interrupt state not at reset values");

endmodule : ptmr_top

// file: bench/tb_ptmr_top.sv
`timescale 1ns/10ps
module tb_ptmr_top;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {logic [31:0] e; logic [31:0] m; logic er; string nm;} ptmr_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_irq, event_irq;
  logic [7:0] paddr, lim, v;
  logic [31:0] pwdata, prdata;
  logic [3:0] pst [4] = '{4'h0, 4'h7, 4'hF, 4'h1};
  int err_count, checked, cyc;
  ptmr_note_s q[$];
  ptmr_note_s nt;

  // Free-running bus clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ptmr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_irq(core_irq), .event_irq(event_irq));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Completed accesses are judged against the oldest note, sampled at the pready edge
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      chk(nt.nm, nt.e & nt.m, prdata & nt.m);
      chk("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
    end
  end

  // Hang guard: well above the longest match wait plus bus traffic
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // APB master: setup, access until pready, then one idle edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic er, input string nm);
    q.push_back('{e, m, er, nm});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until ready is seen; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0, "write");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input string nm);
    xfer(1'b0, a, 32'h0, e, m, 1'b0, nm);
  endtask : rd

  // Level outputs settle within two edges of the write that moves them
  task automatic chs(input string nm, input logic s, input logic e);
    @(posedge pclk);
    chk(nm, {31'h0, e}, {31'h0, s});
  endtask : chs

  task automatic rst_chk();
    rd(ptmr_pkg::OFS_PERIOD_LIMIT, 32'hFF, '1, "limit");
    rd(ptmr_pkg::OFS_COUNT_VALUE, 32'h0, '1, "count");
    rd(ptmr_pkg::OFS_TIMER_TWO_CONTROL, 32'h0, '1, "control");
    rd(ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE, 32'h0, '1, "flags");
    rd(ptmr_pkg::OFS_PERIPHERAL_ENABLES_ONE, 32'h0, '1, "enables");
    rd(ptmr_pkg::OFS_INTERRUPT_CONTROL, 32'h0, 32'hFFFF_FFFE, "intctl");
  endtask : rst_chk

  // One flag period: limit+1 ticks per match, prescale divides, postscale counts matches
  task automatic run_case(input logic [1:0] pre, input logic [3:0] ps);
    int dv, e, n;
    dv = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
    e = (int'(lim) + 1) * dv * (int'(ps) + 1);
    wr(ptmr_pkg::OFS_PERIOD_LIMIT, {24'h0, lim});
    wr(ptmr_pkg::OFS_COUNT_VALUE, 32'h0);
    wr(ptmr_pkg::OFS_IRQ_CLEAR, 32'h3);
    wr(ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE, 32'h0);
    wr(ptmr_pkg::OFS_TIMER_TWO_CONTROL, {25'h0, ps, 1'b1, pre});
    n = 0;
    while (event_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    // Match falls e edges after the run write is taken; the wait starts two edges later
    chk("match_delay_ok", 32'h1, {31'h0, (n >= e - 2 && n <= e)});
    wr(ptmr_pkg::OFS_TIMER_TWO_CONTROL, 32'h0);
    rd(ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE, 32'h2, 32'h2, "match_flag");
    rd(ptmr_pkg::OFS_IRQ_STATUS, 32'h3, 32'h3, "status");
    $display("test scaler %0d/%0d done", pre, ps);
  endtask : run_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(83846));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rst_chk();
    $display("test reset values done");
    // Bit 7 written high must read back low; run kept off here
    v = 8'($urandom) & 8'hFB;
    wr(ptmr_pkg::OFS_TIMER_TWO_CONTROL, {24'h0, v | 8'h80});
    rd(ptmr_pkg::OFS_TIMER_TWO_CONTROL, {24'h0, v & 8'h7B}, '1, "control");
    wr(ptmr_pkg::OFS_COUNT_VALUE, 32'h5);
    repeat (20) @(posedge pclk);
    rd(ptmr_pkg::OFS_COUNT_VALUE, 32'h5, '1, "stopped_count");
    xfer(1'b1, 8'h24, 32'hFF, 32'h0, 32'h0, 1'b1, "bad_write");
    xfer(1'b0, 8'h24, 32'h0, 32'h0, '1, 1'b1, "bad_read");
    $display("test control and bus done");
    wr(ptmr_pkg::OFS_IRQ_ENABLE, 32'h1);
    lim = 8'(1 + $urandom_range(2, 0));
    for (int i = 0; i < 4; i++) begin
      run_case(i[1:0], pst[i]);
      if (i == 0) begin
        chs("core_irq", core_irq, 1'b0);
        wr(ptmr_pkg::OFS_PERIPHERAL_ENABLES_ONE, 32'h82);
        wr(ptmr_pkg::OFS_INTERRUPT_CONTROL, 32'hC0);
        chs("core_irq", core_irq, 1'b1);
        wr(ptmr_pkg::OFS_INTERRUPT_CONTROL, 32'h80);
        chs("core_irq", core_irq, 1'b0);
        wr(ptmr_pkg::OFS_INTERRUPT_CONTROL, 32'hC0);
        wr(ptmr_pkg::OFS_PERIPHERAL_FLAGS_ONE, 32'h80);
        chs("core_irq", core_irq, 1'b0);
        wr(ptmr_pkg::OFS_IRQ_ENABLE, 32'h0);
        chs("event_irq", event_irq, 1'b0);
        wr(ptmr_pkg::OFS_IRQ_ENABLE, 32'h1);
        chs("event_irq", event_irq, 1'b1);
        wr(ptmr_pkg::OFS_IRQ_CLEAR, 32'h1);
        chs("event_irq", event_irq, 1'b0);
        $display("test interrupts done");
      end
    end
    // Second reset while running must restore the six registers read by rst_chk and clear core_irq
    wr(ptmr_pkg::OFS_PERIOD_LIMIT, 32'h10);
    wr(ptmr_pkg::OFS_TIMER_TWO_CONTROL, 32'h04);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rst_chk();
    chs("core_irq", core_irq, 1'b0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_ptmr_top
